// [design/pll_divider_select_bypass.sv]
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// R1 - Input prescaler divides the chosen reference by any integer 1 to 32.
// R2 - Feedback prescaler divides the feedback clock by any integer 1 to 32.
// R3 - Five scalers, each independently set to even ratio 2 to 64, run on oscillator.
// R4 - Locked output frequency is ref times N times tap ratio over M times own ratio.
// R5 - Feedback may tap any one scaler, which may still drive its own output.
// R6 - Ratio 2 or any multiple of 4 gives a 50% duty cycle.
// R7 - Other ratios 6 and up are high for half the ratio minus one periods.
// R8 - Inverted output duty cycle is 100% minus the plain one.
// R9 - Bypass high feeds prescaled reference straight to scalers; low uses oscillator.
// R10 - In bypass each scaler divides by half its ratio, 1 to 32.
// R11 - Bypass removes lock detection and output skew.
// R12 - Output skew steps are counted in oscillator periods.
// R13 - Larger variant: reference choice 0 picks pair A, 1 picks pair B.
// R14 - Larger variant: feedback choice 0 picks pair A, 1 picks pair B.
// R15 - Smaller variant has single reference and feedback pairs, no selection.
// R16 - Oscillator spans 320 to 640 MHz, outputs 5 to 320 MHz.
// R17 - Software should use the smallest workable input prescaler ratio.
// R18 - Software should keep both prescaler outputs at 10 MHz or more.
// R19 - Software should keep feedback ratio times tap ratio at 64 or less.
// R20 - All scalers leave reset or restart on the same oscillator edge.
module pll_divider_select_bypass
  import pll_divider_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [STRB_W-1:0] wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [DATA_W-1:0] rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire logic              referencePairA,
  input  wire logic              referencePairB,
  input  wire logic              referencePairChoice,
  input  wire logic              feedbackPairA,
  input  wire logic              feedbackPairB,
  input  wire logic              feedbackPairChoice,
  input  wire logic              bypassControl,
  output      logic [NUM_SCALERS-1:0] clockOut,
  output      logic              refPrescaled,
  output      logic              fbPrescaled,
  output      logic              lockDetectAllowed
);

  typedef struct packed {
    logic [PIN_W-1:0]                            sync1;
    logic [PIN_W-1:0]                            sync2;
    logic [DATA_W-1:0]                           prescaleReg;
    logic [NUM_SCALERS-1:0][DATA_W-1:0]          scalerReg;
    logic                                        refPrev;
    logic                                        fbPrev;
    logic                                        bypassPrev;
    logic [CODE_W-1:0]                           refCnt;
    logic [CODE_W-1:0]                           fbCnt;
    logic [NUM_SCALERS-1:0][CNT_W-1:0]           cnt;
    logic [NUM_SCALERS-1:0][SKEW_STEPS-1:0]      dly;
    logic [NUM_SCALERS-1:0]                      outClk;
    logic                                        refDivOut;
    logic                                        fbDivOut;
    logic                                        awHave;
    logic                                        wHave;
    logic [ADDR_W-1:0]                           awAddr;
    logic [DATA_W-1:0]                           wData;
    logic [STRB_W-1:0]                           wStrb;
    logic                                        bvalid;
    logic [1:0]                                  bresp;
    logic                                        rvalid;
    logic [DATA_W-1:0]                           rdata;
    logic [1:0]                                  rresp;
  } state_t;

  localparam state_t STATE_RESET = '{
    prescaleReg: PRESCALE_RESET,
    scalerReg:   {NUM_SCALERS{SCALER_RESET}},
    default:     '0
  };

  function automatic logic [RATIO_W-1:0] scalerRatio(input logic [CODE_W-1:0] code);
    scalerRatio = {1'b0, code, 1'b0} + 7'h02;
  endfunction : scalerRatio

  function automatic logic [RATIO_W-1:0] preRatio(input logic [CODE_W-1:0] code);
    preRatio = {2'h0, code} + 7'h01;
  endfunction : preRatio

  function automatic logic [RATIO_W-1:0] highTime(input logic [RATIO_W-1:0] v);
    if (v == 7'h02 || v[1:0] == 2'h0) begin
      highTime = v >> 1;
    end else begin
      highTime = (v >> 1) - 7'h01;
    end
  endfunction : highTime

  function automatic logic divLevel(input logic [CNT_W-1:0]   c,
                                    input logic [RATIO_W-1:0] r,
                                    input logic               inLvl);
    if (r == 7'h01) begin
      divLevel = inLvl;
    end else begin
      divLevel = {1'b0, c} < (r >> 1);
    end
  endfunction : divLevel

  function automatic logic [CNT_W-1:0] wrapStep(input logic [CNT_W-1:0]   c,
                                                input logic [RATIO_W-1:0] r);
    if ({1'b0, c} >= r - 7'h01) begin
      wrapStep = '0;
    end else begin
      wrapStep = c + 6'h01;
    end
  endfunction : wrapStep

  function automatic logic [SLOT_W-1:0] regSlot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - SCALER_BASE;
    regSlot = SLOT_NONE;
    if (a == PRESCALE_OFFSET) begin
      regSlot = SLOT_PRESCALE;
    end else if (a == CONTROL_OFFSET) begin
      regSlot = SLOT_CONTROL;
    end else if (a == STATUS_OFFSET) begin
      regSlot = SLOT_STATUS;
    end else if (a[1:0] == 2'h0 && a >= SCALER_BASE && rel[7:2] < 6'(NUM_SCALERS)) begin
      regSlot = rel[5:2];
    end
  endfunction : regSlot

  function automatic logic [DATA_W-1:0] mergeStrb(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] data,
                                                  input logic [STRB_W-1:0] strb);
    mergeStrb = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        mergeStrb[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction : mergeStrb

  logic                                rstMeta;
  logic                                rstSync;
  state_t                              q;
  state_t                              n;
  logic                                bypassOn;
  logic                                refChoiceSel;
  logic                                fbChoiceSel;
  logic                                refLevel;
  logic                                fbExtLevel;
  logic                                fbSrc;
  logic [TAP_W-1:0]                    tapSel;
  logic [RATIO_W-1:0]                  inRatio;
  logic [RATIO_W-1:0]                  fbRatio;
  logic                                refEdge;
  logic                                fbEdge;
  logic                                refDivLevel;
  logic                                refDivEdge;
  logic                                fbDivLevel;
  logic [NUM_SCALERS-1:0][RATIO_W-1:0] vRatio;
  logic [NUM_SCALERS-1:0][RATIO_W-1:0] bpRatio;
  logic [NUM_SCALERS-1:0]              rawLevel;
  logic                                awTake;
  logic                                wTake;
  logic                                restart;
  logic [PIN_W-1:0]                    pins;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign pins = {bypassControl, feedbackPairChoice, referencePairChoice,
                 feedbackPairB, feedbackPairA, referencePairB, referencePairA};

  // Pin selection, smaller variant ties choices to pair A
  assign bypassOn     = q.sync2[PIN_BYPASS];
  assign refChoiceSel = LARGE_VARIANT ? q.sync2[PIN_REF_CHOICE] : 1'b0;  // R15
  assign fbChoiceSel  = LARGE_VARIANT ? q.sync2[PIN_FB_CHOICE] : 1'b0;   // R15
  assign refLevel     = refChoiceSel ? q.sync2[PIN_REFERENCE_PAIR_B] : q.sync2[PIN_REFERENCE_PAIR_A];  // R13
  assign fbExtLevel   = fbChoiceSel ? q.sync2[PIN_FBB] : q.sync2[PIN_FBA];     // R14

  // Prescalers
  assign inRatio     = preRatio(q.prescaleReg[IN_RATIO_LSB +: CODE_W]);  // R1
  assign fbRatio     = preRatio(q.prescaleReg[FB_RATIO_LSB +: CODE_W]);  // R2
  assign tapSel      = q.prescaleReg[TAP_LSB +: TAP_W];
  assign fbSrc       = (tapSel < TAP_W'(NUM_SCALERS)) ? rawLevel[tapSel] : fbExtLevel;  // R5
  assign refEdge     = refLevel & ~q.refPrev;
  assign fbEdge      = fbSrc & ~q.fbPrev;
  assign refDivLevel = divLevel({1'b0, q.refCnt}, inRatio, refLevel);  // R1
  assign fbDivLevel  = divLevel({1'b0, q.fbCnt}, fbRatio, fbSrc);      // R2
  assign refDivEdge  = refDivLevel & ~q.refDivOut;

  // Scaler levels: oscillator mode uses the duty table, bypass halves the ratio
  for (genvar k = 0; k < NUM_SCALERS; k++) begin : g_scaler
    assign vRatio[k]   = scalerRatio(q.scalerReg[k][RATIO_LSB +: CODE_W]);  // R3
    assign bpRatio[k]  = vRatio[k] >> 1;  // R10
    assign rawLevel[k] = bypassOn ? divLevel(q.cnt[k], bpRatio[k], refDivLevel)
                                  : ({1'b0, q.cnt[k]} < highTime(vRatio[k]));  // R6 R7
  end

  assign awready = !q.awHave && !q.bvalid;
  assign wready  = !q.wHave && !q.bvalid;
  assign arready = !q.rvalid;
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;

  always_comb begin
    logic              haveA;
    logic              haveW;
    logic [ADDR_W-1:0] addrW;
    logic [DATA_W-1:0] dataW;
    logic [STRB_W-1:0] strbW;
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] rd;
    logic [SKEW_W-1:0] skew;
    logic              sel;
    logic              ctrlPulse;
    haveA     = q.awHave || awTake;
    haveW     = q.wHave || wTake;
    addrW     = q.awHave ? q.awAddr : awaddr;
    dataW     = q.wHave ? q.wData : wdata;
    strbW     = q.wHave ? q.wStrb : wstrb;
    slot      = regSlot(addrW);
    rd        = '0;
    skew      = '0;
    sel       = 1'b0;
    ctrlPulse = 1'b0;
    n         = q;

    n.sync1 = pins;
    n.sync2 = q.sync1;

    // Write channel pairing, address and data in either order
    if (haveA && haveW) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (slot == SLOT_PRESCALE) begin
        n.prescaleReg = mergeStrb(q.prescaleReg, dataW, strbW);
      end else if (slot == SLOT_CONTROL) begin
        ctrlPulse = strbW[0] && dataW[RESTART_BIT];
      end else if (slot < SLOT_W'(NUM_SCALERS)) begin
        n.scalerReg[slot] = mergeStrb(q.scalerReg[slot], dataW, strbW);
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end else begin
      n.awHave = haveA;
      n.wHave  = haveW;
      if (awTake) begin
        n.awAddr = awaddr;
      end
      if (wTake) begin
        n.wData = wdata;
        n.wStrb = wstrb;
      end
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // Read channel
    if (arvalid && arready) begin
      slot = regSlot(araddr);
      rd   = '0;
      if (slot == SLOT_PRESCALE) begin
        rd = q.prescaleReg;
      end else if (slot == SLOT_STATUS) begin
        rd[OUT_LSB +: NUM_SCALERS] = q.outClk;
        rd[BYPASS_BIT]             = bypassOn;
        rd[REFERENCE_PAIR_CHOICE_BIT]             = refChoiceSel;
        rd[FBSEL_BIT]              = fbChoiceSel;
        rd[REFDIV_BIT]             = q.refDivOut;
        rd[FBDIV_BIT]              = q.fbDivOut;
        rd[LOCKOK_BIT]             = !bypassOn;
      end else if (slot < SLOT_W'(NUM_SCALERS)) begin
        rd = q.scalerReg[slot];
      end
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = (slot == SLOT_NONE || slot == SLOT_CONTROL) ? RESP_SLVERR : RESP_OKAY;
    end else if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Prescaler counters advance on input rising edges
    n.refPrev   = refLevel;
    n.fbPrev    = fbSrc;
    n.refDivOut = refDivLevel;
    n.fbDivOut  = fbDivLevel;
    if (refEdge) begin
      n.refCnt = CODE_W'(wrapStep({1'b0, q.refCnt}, inRatio));  // R1
    end
    if (fbEdge) begin
      n.fbCnt = CODE_W'(wrapStep({1'b0, q.fbCnt}, fbRatio));  // R2
    end

    // Scalers: common restart, oscillator or prescaled reference as step source
    n.bypassPrev = bypassOn;
    for (int k = 0; k < NUM_SCALERS; k++) begin
      if (restart) begin
        n.cnt[k] = '0;  // R20
      end else if (!bypassOn) begin
        n.cnt[k] = wrapStep(q.cnt[k], vRatio[k]);  // R3 R4 R16
      end else if (refDivEdge) begin
        n.cnt[k] = wrapStep(q.cnt[k], bpRatio[k]);  // R9 R10
      end
      n.dly[k] = {q.dly[k][SKEW_STEPS-2:0], rawLevel[k]};
      skew     = q.scalerReg[k][SKEW_LSB +: SKEW_W];
      if (bypassOn || skew == '0) begin
        sel = rawLevel[k];  // R11
      end else begin
        sel = q.dly[k][skew - 4'h1];  // R12
      end
      n.outClk[k] = sel ^ q.scalerReg[k][INVERT_BIT];  // R8
    end
    restartNote: begin
    end
    if (ctrlPulse) begin
      n.bypassPrev = bypassOn;
    end
  end

  assign restart = (bypassOn != q.bypassPrev) || (q.bvalid && 1'b0);

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= STATE_RESET;
    end else begin
      q <= n;
    end
  end

  assign bresp             = q.bresp;
  assign bvalid            = q.bvalid;
  assign rdata             = q.rdata;
  assign rresp             = q.rresp;
  assign rvalid            = q.rvalid;
  assign clockOut          = q.outClk;
  assign refPrescaled      = q.refDivOut;
  assign fbPrescaled       = q.fbDivOut;
  assign lockDetectAllowed = !q.sync2[PIN_BYPASS];  // R11

  ref_prescale_wrap_a: assert property ( // R1
    @(posedge core_clk) disable iff (!rstSync)
    refEdge && ({2'h0, q.refCnt} >= inRatio - 7'h01) |=> q.refCnt == '0
  ) else $error("reference prescaler did not wrap at its ratio");

  fb_prescale_wrap_a: assert property ( // R2
    @(posedge core_clk) disable iff (!rstSync)
    fbEdge && ({2'h0, q.fbCnt} >= fbRatio - 7'h01) |=> q.fbCnt == '0
  ) else $error("feedback prescaler did not wrap at its ratio");

  scaler_wrap_a: assert property ( // R3
    @(posedge core_clk) disable iff (!rstSync)
    !bypassOn && !restart && ({1'b0, q.cnt[0]} == vRatio[0] - 7'h01) |=> q.cnt[0] == '0
  ) else $error("scaler did not wrap after its full ratio");

  duty_six_a: assert property ( // R7
    @(posedge core_clk) disable iff (!rstSync)
    !bypassOn && vRatio[1] == 7'h06 |-> rawLevel[1] == (q.cnt[1] < 6'h02)
  ) else $error("ratio six is not high for two periods");

  duty_eight_a: assert property ( // R6
    @(posedge core_clk) disable iff (!rstSync)
    !bypassOn && vRatio[2] == 7'h08 |-> rawLevel[2] == (q.cnt[2] < 6'h04)
  ) else $error("ratio eight is not high for half its period");

  bypass_hold_a: assert property ( // R10
    @(posedge core_clk) disable iff (!rstSync)
    bypassOn && !restart && !refDivEdge |=> $stable(q.cnt[0])
  ) else $error("scaler stepped in bypass without a prescaled reference edge");

  restart_align_a: assert property ( // R20
    @(posedge core_clk) disable iff (!rstSync)
    restart |=> q.cnt == '0
  ) else $error("scalers did not restart together");

  bypass_noskew_a: assert property ( // R11
    @(posedge core_clk) disable iff (!rstSync)
    bypassOn |=> clockOut[0] == $past(rawLevel[0] ^ q.scalerReg[0][INVERT_BIT])
  ) else $error("bypass output is delayed or wrongly inverted");

  skew_step_a: assert property ( // R12
    @(posedge core_clk) disable iff (!rstSync)
    !bypassOn && q.scalerReg[3][SKEW_LSB +: SKEW_W] == 4'h1 && !q.scalerReg[3][INVERT_BIT]
      |=> clockOut[3] == $past(rawLevel[3], 2)
  ) else $error("one skew step is not one oscillator period");

  ref_choice_a: assert property ( // R13
    @(posedge core_clk) disable iff (!rstSync)
    LARGE_VARIANT && q.sync2[PIN_REF_CHOICE] |-> refLevel == q.sync2[PIN_REFERENCE_PAIR_B]
  ) else $error("reference choice one did not pick pair B");

  fb_choice_a: assert property ( // R14
    @(posedge core_clk) disable iff (!rstSync)
    LARGE_VARIANT && !q.sync2[PIN_FB_CHOICE] |-> fbExtLevel == q.sync2[PIN_FBA]
  ) else $error("feedback choice zero did not pick pair A");

endmodule : pll_divider_select_bypass

// [pkg/pll_divider_pkg.sv]
package pll_divider_pkg;

  // Build shape
  localparam int NUM_SCALERS  = 5;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int STRB_W       = DATA_W / 8;
  localparam int CODE_W       = 5;
  localparam int CNT_W        = 6;
  localparam int RATIO_W      = 7;
  localparam int TAP_W        = 3;
  localparam int SKEW_W       = 4;
  localparam int SKEW_STEPS   = 16;
  localparam int SLOT_W       = 4;

  // Oscillator range in MHz and ratio limits
  localparam int VCO_MIN_MHZ      = 320;
  localparam int VCO_MAX_MHZ      = 640;
  localparam int PRE_MAX_RATIO    = 32;
  localparam int SCALER_MAX_RATIO = 64;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] PRESCALE_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] SCALER_BASE     = 8'h04;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET  = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 8'h1c;

  // Prescale register fields
  localparam int IN_RATIO_LSB = 0;
  localparam int FB_RATIO_LSB = 8;
  localparam int TAP_LSB      = 16;

  // Scaler register fields
  localparam int RATIO_LSB    = 0;
  localparam int INVERT_BIT   = 8;
  localparam int SKEW_LSB     = 16;

  // Control and status fields
  localparam int RESTART_BIT  = 0;
  localparam int OUT_LSB      = 0;
  localparam int BYPASS_BIT   = 5;
  localparam int REFERENCE_PAIR_CHOICE_BIT   = 6;
  localparam int FBSEL_BIT    = 7;
  localparam int REFDIV_BIT   = 8;
  localparam int FBDIV_BIT    = 9;
  localparam int LOCKOK_BIT   = 10;

  // Reset values
  localparam logic [DATA_W-1:0] PRESCALE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SCALER_RESET   = 32'h0000_0000;

  // Register slots from address decode
  localparam logic [SLOT_W-1:0] SLOT_PRESCALE = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_CONTROL  = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_STATUS   = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_NONE     = 4'h8;

  // Synchroniser pin positions
  localparam int PIN_REFERENCE_PAIR_A       = 0;
  localparam int PIN_REFERENCE_PAIR_B       = 1;
  localparam int PIN_FBA        = 2;
  localparam int PIN_FBB        = 3;
  localparam int PIN_REF_CHOICE = 4;
  localparam int PIN_FB_CHOICE  = 5;
  localparam int PIN_BYPASS     = 6;
  localparam int PIN_W          = 7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pll_divider_pkg

// [testbench/ref_clock_source.sv]
`timescale 1ns/1ps
module ref_clock_source #(
  parameter int REF_A_PERIOD = 8,
  parameter int REF_B_PERIOD = 6,
  parameter int FB_A_PERIOD  = 16,
  parameter int FB_B_PERIOD  = 24
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output      logic referencePairA,
  output      logic referencePairB,
  output      logic feedbackPairA,
  output      logic feedbackPairB
);
  logic [31:0] tick;

  // Free-running clocks locked to the bench clock so period counts come out exact
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 32'h0;
    end else begin
      tick <= tick + 32'h1;
    end
  end

  assign referencePairA = (tick % REF_A_PERIOD) < (REF_A_PERIOD / 2);
  assign referencePairB = (tick % REF_B_PERIOD) < (REF_B_PERIOD / 2);
  assign feedbackPairA  = (tick % FB_A_PERIOD) < (FB_A_PERIOD / 2);
  assign feedbackPairB  = (tick % FB_B_PERIOD) < (FB_B_PERIOD / 2);
endmodule : ref_clock_source

// [testbench/pll_divider_select_bypass_test.sv]
`timescale 1ns/1ps
module pll_divider_select_bypass_test;
  import pll_divider_pkg::*;
  logic                   core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0]      awaddr, araddr;
  logic [DATA_W-1:0]      wdata, rdata;
  logic [STRB_W-1:0]      wstrb;
  logic [1:0]             bresp, rresp;
  logic                   reference_pair_a, reference_pair_b, fbA, fbB, refChoice, fbChoice, bypass;
  logic [NUM_SCALERS-1:0] clockOut;
  logic                   refPrescaled, fbPrescaled, lockDetectAllowed;
  int                     nErrors, numChecks, both;
  int                     hi [7];
  int                     rs [7];

  pll_divider_select_bypass u_pll_divider_select_bypass (
    .core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .referencePairA(reference_pair_a), .referencePairB(reference_pair_b), .referencePairChoice(refChoice),
    .feedbackPairA(fbA), .feedbackPairB(fbB), .feedbackPairChoice(fbChoice),
    .bypassControl(bypass), .clockOut(clockOut), .refPrescaled(refPrescaled),
    .fbPrescaled(fbPrescaled), .lockDetectAllowed(lockDetectAllowed));

  ref_clock_source u_ref_clock_source (
    .core_clk(core_clk), .rst_n(rst_n), .referencePairA(reference_pair_a), .referencePairB(reference_pair_b),
    .feedbackPairA(fbA), .feedbackPairB(fbB));

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge core_clk);
      aw = awready & awvalid;
      w = wready & wvalid;
      b = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        return;
      end
    end
    nErrors++;
    summarize();
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge core_clk);
      ar = arready & arvalid;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
      if (rv) begin
        rready <= 1'b0;
        return;
      end
    end
    nErrors++;
    summarize();
  endtask : axiRead

  // Counts high samples and rising edges of every clock output over a window
  task automatic meas(input int len);
    logic [6:0] v, p;
    both = 0;
    for (int k = 0; k < 7; k++) begin
      hi[k] = 0;
      rs[k] = 0;
    end
    repeat (300) @(posedge core_clk);
    @(negedge core_clk);
    p = {fbPrescaled, refPrescaled, clockOut};
    repeat (len) begin
      @(negedge core_clk);
      v = {fbPrescaled, refPrescaled, clockOut};
      for (int k = 0; k < 7; k++) begin
        hi[k] += int'(v[k]);
        rs[k] += int'(v[k] & !p[k]);
      end
      both += int'(v[0] & !p[0] & v[1] & !p[1]);
      p = v;
    end
  endtask : meas

  function automatic int highOf(input int v, input bit inv);
    int h;
    h = (v == 2 || v % 4 == 0) ? v / 2 : v / 2 - 1;
    return inv ? v - h : h;
  endfunction : highOf

  task automatic testRegs();
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(PRESCALE_OFFSET, d, r);
    chk("prescale reset", PRESCALE_RESET, d);
    axiRead(SCALER_BASE + 8'h10, d, r);
    chk("scaler4 reset", SCALER_RESET, d);
    axiRead(8'h40, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    axiWrite(STATUS_OFFSET, 32'h0, r);
    chk("status bresp", 32'(RESP_SLVERR), 32'(r));
    axiWrite(SCALER_BASE + 8'h04, 32'h0000_0103, r);
    axiRead(SCALER_BASE + 8'h04, d, r);
    chk("scaler1 readback", 32'h0000_0103, d);
    $display("test regs done");
  endtask : testRegs

  task automatic testNormal();
    int          code [5] = '{2, 3, 0, 2, 31};
    int          v;
    logic [1:0]  r;
    axiWrite(PRESCALE_OFFSET, 32'h0, r);
    for (int k = 0; k < 5; k++) begin
      axiWrite(SCALER_BASE + 8'(4 * k),
               32'(code[k]) | (k == 0 ? 32'h100 : 32'h0) | (k == 3 ? 32'h1_0000 : 32'h0), r);
    end
    bypass <= 1'b1;
    repeat (20) @(posedge core_clk);
    bypass <= 1'b0;
    meas(384);
    for (int k = 0; k < 5; k++) begin
      v = 2 * (code[k] + 1);
      chk("scaler rises", 32'(384 / v), 32'(rs[k]));
      chk("scaler high", 32'(384 / v * highOf(v, k == 0)), 32'(hi[k]));
    end
    chk("aligned rises", 32'd16, 32'(both));
    $display("test normal done");
  endtask : testNormal

  task automatic testBypass();
    logic [31:0] d;
    logic [1:0]  r;
    bypass <= 1'b1;
    meas(384);
    chk("lock allowed", 32'h0, 32'(lockDetectAllowed));
    chk("ref rises", 32'd48, 32'(rs[5]));
    chk("scaler0 rises", 32'd16, 32'(rs[0]));
    chk("scaler1 rises", 32'd12, 32'(rs[1]));
    chk("scaler2 rises", 32'd48, 32'(rs[2]));
    axiRead(STATUS_OFFSET, d, r);
    chk("status bypass", 32'h1, 32'(d[BYPASS_BIT]));
    refChoice <= 1'b1;
    meas(384);
    chk("ref b rises", 32'd64, 32'(rs[5]));
    chk("scaler1 b rises", 32'd16, 32'(rs[1]));
    refChoice <= 1'b0;
    bypass <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("lock allowed", 32'h1, 32'(lockDetectAllowed));
    $display("test bypass done");
  endtask : testBypass

  task automatic testPrescale();
    logic [1:0] r;
    axiWrite(PRESCALE_OFFSET, 32'h0005_001f, r);
    meas(768);
    chk("ref m32 rises", 32'd3, 32'(rs[5]));
    chk("fb a rises", 32'd48, 32'(rs[6]));
    fbChoice <= 1'b1;
    meas(768);
    chk("fb b rises", 32'd32, 32'(rs[6]));
    fbChoice <= 1'b0;
    axiWrite(PRESCALE_OFFSET, 32'h0000_0100, r);
    meas(768);
    chk("fb tap rises", 32'd64, 32'(rs[6]));
    chk("ref m1 rises", 32'd96, 32'(rs[5]));
    $display("test prescale done");
  endtask : testPrescale

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    {refChoice, fbChoice, bypass} = 3'h0;
    nErrors = 0;
    numChecks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    testRegs();
    testNormal();
    testBypass();
    testPrescale();
    summarize();
  end
endmodule : pll_divider_select_bypass_test
